// ### src/lcc_lane_regs.sv
// Purpose: AXI4-Lite register group configuring one repeater lane.
// Assumes: Bus master keeps AXI4-Lite rules; one write, one read at a time.
// Notes:   Only byte lane 0 carries data; upper bytes read zero.
`timescale 1ns/1ps
`default_nettype none

module lcc_lane_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // Write data channel
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // Write response channel
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // Read data channel
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Lane settings
  output lcc_pkg::lcc_lane_cfg_s    lane_cfg
);

  // ************************************************************
  // State
  // ************************************************************
  lcc_pkg::lcc_wr_e                        wr_st_q, wr_st_d;
  lcc_pkg::lcc_rd_e                        rd_st_q, rd_st_d;
  logic                                    aw_held_q, aw_held_d;
  logic                                    w_held_q, w_held_d;
  logic [ADDR_W-1:0]                       waddr_q, waddr_d;
  logic [7:0]                              wbyte_q, wbyte_d;
  logic                                    wlane0_q, wlane0_d;
  logic [1:0]                              bresp_q, bresp_d;
  logic [31:0]                             rdata_q, rdata_d;
  logic [1:0]                              rresp_q, rresp_d;
  logic                                    wr_fire;
  logic [lcc_pkg::NUM_REGS-1:0]            whit;
  logic [lcc_pkg::NUM_REGS-1:0]            rhit;
  logic [lcc_pkg::NUM_REGS-1:0][7:0]       bank;
  lcc_pkg::lcc_regs_s                      regs;
  logic [5:0]                              unused_prot;

  // Protection bits carry no meaning for this group
  assign unused_prot = {awprot, arprot};

  // ************************************************************
  // Address decode
  // ************************************************************
  // Index compare on the word address; byte offset bits ignored
  always_comb begin
    for (int i = 0; i < lcc_pkg::NUM_REGS; i++) begin
      whit[i] = ((waddr_q >> 2) == ADDR_W'(lcc_pkg::REG_IDX[i]));
      rhit[i] = ((araddr >> 2) == ADDR_W'(lcc_pkg::REG_IDX[i]));
    end
  end

  // ************************************************************
  // Write path
  // ************************************************************
  // Address and data are caught separately, then committed together
  assign awready = (wr_st_q == lcc_pkg::WR_WAIT) && !aw_held_q;
  assign wready  = (wr_st_q == lcc_pkg::WR_WAIT) && !w_held_q;
  assign wr_fire = (wr_st_q == lcc_pkg::WR_WAIT) && aw_held_q && w_held_q;
  assign bvalid  = (wr_st_q == lcc_pkg::WR_RESP);
  assign bresp   = bresp_q;

  // Write channel next state
  always_comb begin
    wr_st_d   = wr_st_q;
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane0_d  = wlane0_q;
    bresp_d   = bresp_q;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      wbyte_d  = wdata[7:0];
      wlane0_d = wstrb[0];
    end
    case (wr_st_q)
      lcc_pkg::WR_WAIT: begin
        if (wr_fire) begin
          wr_st_d   = lcc_pkg::WR_RESP;
          aw_held_d = 1'b0;
          w_held_d  = 1'b0;
          bresp_d   = (|whit) ? lcc_pkg::RESP_OKAY : lcc_pkg::RESP_SLVERR;
        end
      end
      lcc_pkg::WR_RESP: begin
        if (bready) begin
          wr_st_d = lcc_pkg::WR_WAIT;
        end
      end
      default: begin
        wr_st_d = lcc_pkg::WR_WAIT;
      end
    endcase
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_q   <= lcc_pkg::WR_WAIT;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane0_q  <= 1'b0;
      bresp_q   <= lcc_pkg::RESP_OKAY;
    end else begin
      wr_st_q   <= wr_st_d;
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane0_q  <= wlane0_d;
      bresp_q   <= bresp_d;
    end
  end

  // ************************************************************
  // Register bank
  // ************************************************************
  // A write with strobe 0 clear is answered OKAY but stores nothing
  for (genvar g = 0; g < lcc_pkg::NUM_REGS; g++) begin : g_cell
    lcc_reg_cell #(
      .RST  (lcc_pkg::REG_RST[g]),
      .MASK (lcc_pkg::REG_MASK[g])
    ) u_cell (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (wr_fire && whit[g] && wlane0_q),
      .wdata   (wbyte_q),
      .q       (bank[g])
    );
  end

  assign regs = lcc_pkg::lcc_regs_s'(bank);

  // Field decode towards the analog lane
  lcc_field_decode u_decode (
    .aclk    (aclk),
    .aresetn (aresetn),
    .regs    (regs),
    .cfg_q   (lane_cfg)
  );

  // ************************************************************
  // Read path
  // ************************************************************
  assign arready = (rd_st_q == lcc_pkg::RD_IDLE);
  assign rvalid  = (rd_st_q == lcc_pkg::RD_DATA);
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Read channel next state; unmapped reads answer zero with SLVERR
  always_comb begin
    rd_st_d = rd_st_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_st_q)
      lcc_pkg::RD_IDLE: begin
        if (arvalid) begin
          rd_st_d = lcc_pkg::RD_DATA;
          rdata_d = 32'h0000_0000;
          rresp_d = lcc_pkg::RESP_SLVERR;
          for (int i = 0; i < lcc_pkg::NUM_REGS; i++) begin
            if (rhit[i]) begin
              rdata_d = {24'h00_0000, bank[i]};
              rresp_d = lcc_pkg::RESP_OKAY;
            end
          end
        end
      end
      lcc_pkg::RD_DATA: begin
        if (rready) begin
          rd_st_d = lcc_pkg::RD_IDLE;
        end
      end
      default: begin
        rd_st_d = lcc_pkg::RD_IDLE;
      end
    endcase
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_q <= lcc_pkg::RD_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= lcc_pkg::RESP_OKAY;
    end else begin
      rd_st_q <= rd_st_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_auto_gate: assert property (
    ##1 lane_cfg.signal_detect_gate == $past(bank[0][5])
  ) else $error("signal detect gate does not follow idle auto");

  a_idle_force_mute: assert property (
    ##1 lane_cfg.output_mute_force == $past(bank[0][5:4] == 2'h1)
  ) else $error("forced mute not taken from idle select");

  a_rate_auto_flag: assert property (
    ##1 lane_cfg.rate_detect_auto == $past(bank[0][1])
  ) else $error("rate auto flag wrong");

  a_rate_force_sel: assert property (
    ##1 lane_cfg.rate_5g_select == $past(bank[0][1:0] == 2'h1)
  ) else $error("forced rate select wrong");

  a_eq_field_split: assert property (
    ##1 {lane_cfg.eq_enable, lane_cfg.gain_stage_field,
         lane_cfg.boost_level_field} == $past(bank[1][5:0])
  ) else $error("equalizer fields misdecoded");

  a_eq_bypass_code: assert property (
    ##1 lane_cfg.eq_bypass == $past(bank[1] == 8'h20)
  ) else $error("equalizer bypass flag wrong");

  a_swing_600mv: assert property (
    (bank[2] == 8'h03) |=> (lane_cfg.swing_mv == 11'h258) && lane_cfg.swing_valid
  ) else $error("swing 03h not 600 mV");

  a_swing_1400mv: assert property (
    (bank[2] == 8'h3F) |=> (lane_cfg.swing_mv == 11'h578)
  ) else $error("swing 3Fh not 1400 mV");

  a_emph_type_bit: assert property (
    ##1 lane_cfg.emphasis_enhanced == $past(bank[3][7])
  ) else $error("emphasis type wrong");

  a_emph_level_db: assert property (
    (bank[3] == 8'hE8) |=> (lane_cfg.emphasis_db_tenths == 8'h23) && lane_cfg.emphasis_valid
  ) else $error("emphasis E8h not 3.5 dB");

  // Reserved and undocumented bytes must never report a level
  a_emph_valid_codes: assert property (
    ##1 lane_cfg.emphasis_valid == $past(bank[3] == 8'h01 || bank[3] == 8'hE8
                                      || bank[3] == 8'h88 || bank[3] == 8'h90
                                      || bank[3] == 8'hA0)
  ) else $error("emphasis valid flag wrong for stored byte");

  a_thresh_levels: assert property (
    (bank[4][3:0] == 4'h6) |=> (lane_cfg.idle_deassert_mv == 8'h96)
                            && (lane_cfg.idle_assert_mv == 8'h82)
  ) else $error("threshold split wrong");

  a_thresh_default: assert property (
    (bank[4][3:0] == 4'h0) |=> (lane_cfg.idle_deassert_mv == 8'h6E)
                            && (lane_cfg.idle_assert_mv == 8'h46)
  ) else $error("threshold 00 not 110/70 mV");

  a_reset_values: assert property (
    $rose(aresetn) |-> (bank == {8'h00, 8'h03, 8'h03, 8'h20, 8'h00})
                    && lane_cfg.eq_bypass
  ) else $error("reset values wrong");

  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)
  ) else $error("write response dropped before taken");

endmodule
`default_nettype wire

// ### src/lcc_pkg.sv
// Purpose: Constants and types of the lane conditioning register group.
// Assumes: One lane, five byte registers on a 32-bit register bus.
// Notes:   Byte address of a register is four times its index.

package lcc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int           NUM_REGS = 5;
  localparam int           IDX_W    = 6;
  localparam logic [5:0]   IDX_IDLE_RATE = 6'h23;
  localparam logic [5:0]   IDX_EQ        = 6'h24;
  localparam logic [5:0]   IDX_SWING     = 6'h25;
  localparam logic [5:0]   IDX_EMPH      = 6'h26;
  localparam logic [5:0]   IDX_THRESH    = 6'h27;
  localparam logic [NUM_REGS-1:0][5:0] REG_IDX =
    {IDX_THRESH, IDX_EMPH, IDX_SWING, IDX_EQ, IDX_IDLE_RATE};
  // Reset values, slot 0 is the idle/rate register
  localparam logic [NUM_REGS-1:0][7:0] REG_RST =
    {8'h00, 8'h03, 8'h03, 8'h20, 8'h00};
  // Writable bits; reserved bits are held at zero
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK =
    {8'h0F, 8'hFF, 8'h7F, 8'h3F, 8'h33};

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int           IDLE_AUTO_BIT = 5;
  localparam int           IDLE_SEL_BIT  = 4;
  localparam int           RATE_AUTO_BIT = 1;
  localparam int           RATE_SEL_BIT  = 0;
  localparam int           EQ_EN_BIT     = 5;
  localparam int           EMPH_TYPE_BIT = 7;
  localparam logic [5:0]   EQ_BYPASS     = 6'h20;
  localparam logic [8:0][5:0] EQ_SETTINGS =
    {6'h20, 6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, 6'h3B, 6'h3D};
  localparam logic [4:0][6:0]  SWING_CODE =
    {7'h03, 7'h07, 7'h0F, 7'h1F, 7'h3F};
  localparam logic [4:0][10:0] SWING_MV =
    {11'h258, 11'h320, 11'h3E8, 11'h4B0, 11'h578};
  localparam logic [4:0][7:0]  EMPH_CODE =
    {8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
  // Attenuation in tenths of a dB: 0, 35, 60, 90, 120
  localparam logic [4:0][7:0]  EMPH_TENTHS =
    {8'h00, 8'h23, 8'h3C, 8'h5A, 8'h78};
  localparam logic [7:0]   EMPH_RESERVED = 8'hC0;
  // Indexed by code 3..0: 190/150, 170/130, 150/110, 110/70 mV
  localparam logic [3:0][7:0] THR_DEASSERT_MV =
    {8'hBE, 8'hAA, 8'h96, 8'h6E};
  localparam logic [3:0][7:0] THR_ASSERT_MV =
    {8'h96, 8'h82, 8'h6E, 8'h46};

  // ************************************************************
  // Bus answers
  // ************************************************************
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;

  typedef enum logic {WR_WAIT, WR_RESP} lcc_wr_e;
  typedef enum logic {RD_IDLE, RD_DATA} lcc_rd_e;

  // Raw register bank, idle/rate in the low byte
  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] emph;
    logic [7:0] swing;
    logic [7:0] eq;
    logic [7:0] idle_rate;
  } lcc_regs_s;

  // Settings presented to the analog lane
  typedef struct packed {
    logic        idle_detect_auto;
    logic        output_mute_force;
    logic        signal_detect_gate;
    logic        rate_detect_auto;
    logic        rate_5g_select;
    logic        eq_enable;
    logic [1:0]  gain_stage_field;
    logic [2:0]  boost_level_field;
    logic        eq_bypass;
    logic        eq_strap_match;
    logic [6:0]  output_swing;
    logic [10:0] swing_mv;
    logic        swing_valid;
    logic        emphasis_enhanced;
    logic [6:0]  emphasis_level;
    logic [7:0]  emphasis_db_tenths;
    logic        emphasis_valid;
    logic [7:0]  idle_deassert_mv;
    logic [7:0]  idle_assert_mv;
  } lcc_lane_cfg_s;

endpackage

// ### src/lcc_reg_cell.sv
// Purpose: One byte-wide software register with reserved bits masked.
// Assumes: Write enable already qualified by address and byte strobe.
// Notes:   Reserved bits always read as zero.
`timescale 1ns/1ps
`default_nettype none

module lcc_reg_cell #(
  parameter logic [7:0] RST  = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Write side
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  // Stored value
  output logic      [7:0] q
);

  logic [7:0] q_d;

  // Reserved positions never take a one from software
  always_comb begin
    q_d = q;
    if (we) begin
      q_d = wdata & MASK;
    end
  end

  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= q_d;
    end
  end

endmodule
`default_nettype wire

// ### src/lcc_field_decode.sv
// Purpose: Decodes the raw lane registers into analog lane settings.
// Assumes: Raw bank is stable between software writes.
// Notes:   Outputs lag the bank by one clock.
`timescale 1ns/1ps
`default_nettype none

module lcc_field_decode (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Raw bank
  input  wire lcc_pkg::lcc_regs_s    regs,
  // Decoded settings
  output lcc_pkg::lcc_lane_cfg_s     cfg_q
);

  lcc_pkg::lcc_lane_cfg_s cfg_d;

  // Pure field decode, also used for the reset value
  function automatic lcc_pkg::lcc_lane_cfg_s decode(lcc_pkg::lcc_regs_s r);
    lcc_pkg::lcc_lane_cfg_s c;
    c = '0;
    c.idle_detect_auto   = r.idle_rate[lcc_pkg::IDLE_AUTO_BIT];
    c.signal_detect_gate = r.idle_rate[lcc_pkg::IDLE_AUTO_BIT];
    c.output_mute_force  = !r.idle_rate[lcc_pkg::IDLE_AUTO_BIT]
                         && r.idle_rate[lcc_pkg::IDLE_SEL_BIT];
    c.rate_detect_auto   = r.idle_rate[lcc_pkg::RATE_AUTO_BIT];
    c.rate_5g_select     = !r.idle_rate[lcc_pkg::RATE_AUTO_BIT]
                         && r.idle_rate[lcc_pkg::RATE_SEL_BIT];
    c.eq_enable          = r.eq[lcc_pkg::EQ_EN_BIT];
    c.gain_stage_field   = r.eq[4:3];
    c.boost_level_field  = r.eq[2:0];
    c.eq_bypass          = (r.eq[5:0] == lcc_pkg::EQ_BYPASS);
    for (int i = 0; i < 9; i++) begin
      if (r.eq[5:0] == lcc_pkg::EQ_SETTINGS[i]) begin
        c.eq_strap_match = 1'b1;
      end
    end
    c.output_swing = r.swing[6:0];
    for (int i = 0; i < 5; i++) begin
      if (r.swing[6:0] == lcc_pkg::SWING_CODE[i]) begin
        c.swing_mv    = lcc_pkg::SWING_MV[i];
        c.swing_valid = 1'b1;
      end
    end
    c.emphasis_enhanced = r.emph[lcc_pkg::EMPH_TYPE_BIT];
    c.emphasis_level    = r.emph[6:0];
    // C0h and undocumented bytes report invalid, never a level
    for (int i = 0; i < 5; i++) begin
      if (r.emph == lcc_pkg::EMPH_CODE[i]) begin
        c.emphasis_db_tenths = lcc_pkg::EMPH_TENTHS[i];
        c.emphasis_valid     = 1'b1;
      end
    end
    c.idle_deassert_mv = lcc_pkg::THR_DEASSERT_MV[r.thresh[3:2]];
    c.idle_assert_mv   = lcc_pkg::THR_ASSERT_MV[r.thresh[1:0]];
    return c;
  endfunction

  // Next settings
  always_comb begin
    cfg_d = decode(regs);
  end

  // Settings register, reset to the decode of the reset bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= decode(lcc_pkg::lcc_regs_s'(lcc_pkg::REG_RST));
    end else begin
      cfg_q <= cfg_d;
    end
  end

endmodule
`default_nettype wire

// ### tb/tb_lane_conditioning_config_regs.sv
// Purpose: Self-checking bench for the lane conditioning register group.
// Assumes: Bench acts as the AXI4-Lite master, one write or read at a time.
// Notes:   Byte address is four times the register index (0x8C..0x9C).
`timescale 1ns/1ps
`default_nettype none

module tb_lane_conditioning_config_regs;

  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
  } lcc_row_s;

  logic                   aclk;
  logic                   aresetn;
  logic [7:0]             awaddr;
  logic [7:0]             araddr;
  logic                   awvalid;
  logic                   wvalid;
  logic                   bready;
  logic                   arvalid;
  logic                   rready;
  logic [31:0]            wdata;
  logic [3:0]             wstrb;
  logic                   awready;
  logic                   wready;
  logic                   bvalid;
  logic                   arready;
  logic                   rvalid;
  logic [1:0]             bresp;
  logic [1:0]             rresp;
  logic [31:0]            rdata;
  lcc_pkg::lcc_lane_cfg_s lane_cfg;
  int                     error_cnt;
  int                     check_count;
  int                     cyc;

  // Ordinary cases: reserved bits are written as zero, as software must
  lcc_row_s rows [5] = '{'{8'h8C, 8'h33, 8'h33}, '{8'h90, 8'h3D, 8'h3D},
                         '{8'h94, 8'h3F, 8'h3F}, '{8'h98, 8'hA0, 8'hA0},
                         '{8'h9C, 8'h0F, 8'h0F}};
  logic [7:0]  rst_val [5] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
  logic [7:0]  idle_in [4] = '{8'h10, 8'h01, 8'h00, 8'h30};
  logic [3:0]  idle_ex [4] = '{4'h8, 4'h1, 4'h0, 4'h6};
  logic [6:0]  sw_code [5] = '{7'h03, 7'h07, 7'h0F, 7'h1F, 7'h3F};
  logic [10:0] sw_mv   [5] = '{11'h258, 11'h320, 11'h3E8, 11'h4B0, 11'h578};
  logic [7:0]  em_code [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
  logic [7:0]  em_db   [5] = '{8'h00, 8'h23, 8'h3C, 8'h5A, 8'h78};
  logic [7:0]  th_de   [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
  logic [7:0]  th_as   [4] = '{8'h46, 8'h6E, 8'h82, 8'h96};
  logic [5:0]  eq_code [9] = '{6'h20, 6'h2A, 6'h30, 6'h32, 6'h39,
                               6'h35, 6'h37, 6'h3B, 6'h3D};

  // ************************************************************
  // Device and clock
  // ************************************************************
  lcc_lane_regs #(.ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lane_cfg(lane_cfg)
  );

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Watchdog, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    chk("bresp", bresp, r);
    bready <= 1'b0;
    // Extra edge so the decoded settings are settled before checks
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    chk("rdata", rdata, {24'h0, exp});
    chk("rresp", rresp, r);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rst_chk();
    for (int i = 0; i < 5; i++) rd(8'h8C + 8'(4 * i), rst_val[i], 2'h0);
    chk("eq_bypass", lane_cfg.eq_bypass, 1'b1);
    chk("swing_mv", lane_cfg.swing_mv, 11'h258);
    chk("thr", {lane_cfg.idle_deassert_mv, lane_cfg.idle_assert_mv}, 16'h6E46);
    chk("mute", lane_cfg.output_mute_force, 1'b0);
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rst_chk();
    $display("Reset values done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wd, 4'h1, 2'h0);
      rd(rows[i].addr, rows[i].rd, 2'h0);
    end
    chk("auto", {lane_cfg.idle_detect_auto, lane_cfg.signal_detect_gate}, 2'h3);
    chk("rate", {lane_cfg.rate_detect_auto, lane_cfg.rate_5g_select}, 2'h2);
    chk("eq", {lane_cfg.eq_enable, lane_cfg.gain_stage_field, lane_cfg.boost_level_field},
        6'h3D);
    chk("em_type", lane_cfg.emphasis_enhanced, 1'b1);
    chk("thr", {lane_cfg.idle_deassert_mv, lane_cfg.idle_assert_mv}, 16'hBE96);
    $display("Row table done");
    foreach (idle_in[i]) begin
      wr(8'h8C, idle_in[i], 4'h1, 2'h0);
      chk("idle", {lane_cfg.output_mute_force, lane_cfg.signal_detect_gate,
          lane_cfg.idle_detect_auto, lane_cfg.rate_5g_select}, idle_ex[i]);
    end
    $display("Forced modes done");
    // Emphasis codes avoid the reserved byte on purpose
    for (int i = 0; i < 5; i++) begin
      wr(8'h94, {1'b0, sw_code[i]}, 4'h1, 2'h0);
      wr(8'h98, em_code[i], 4'h1, 2'h0);
      chk("swing", {lane_cfg.swing_valid, lane_cfg.swing_mv}, {1'b1, sw_mv[i]});
      chk("swing_code", lane_cfg.output_swing, sw_code[i]);
      chk("em_db", {lane_cfg.emphasis_valid, lane_cfg.emphasis_db_tenths},
          {1'b1, em_db[i]});
      chk("em_level", lane_cfg.emphasis_level, em_code[i][6:0]);
      chk("em_type", lane_cfg.emphasis_enhanced, em_code[i][7]);
      if (i < 4) begin
        wr(8'h9C, {4'h0, 2'(i), 2'(3 - i)}, 4'h1, 2'h0);
        chk("thr", {lane_cfg.idle_deassert_mv, lane_cfg.idle_assert_mv},
            {th_de[i], th_as[3 - i]});
      end
    end
    $display("Level tables done");
    foreach (eq_code[i]) begin
      wr(8'h90, {2'h0, eq_code[i]}, 4'h1, 2'h0);
      chk("eq_map", {lane_cfg.eq_strap_match, lane_cfg.eq_bypass},
          {1'b1, eq_code[i] == 6'h20});
    end
    $display("Equalizer straps done");
    // Unmapped place refused, disabled byte lane leaves the register alone
    wr(8'hA0, 8'h55, 4'h1, 2'h2);
    rd(8'hA0, 8'h00, 2'h2);
    wr(8'h94, 8'h55, 4'h0, 2'h0);
    rd(8'h94, 8'h3F, 2'h0);
    $display("Refusals done");
    // Response held back: bvalid and bresp stand, awready stays low
    awaddr  <= 8'h98;
    wdata   <= 32'h0000_0088;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("bvalid_held", bvalid, 1'b1);
    chk("awready_busy", awready, 1'b0);
    bready  <= 1'b1;
    do @(posedge aclk); while (!(bvalid === 1'b1));
    chk("bresp_held", bresp, 2'h0);
    bready  <= 1'b0;
    @(posedge aclk);
    rd(8'h98, 8'h88, 2'h0);
    $display("Held response done");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rst_chk();
    $display("Second reset done");
    results();
  end

endmodule
`default_nettype wire
